// ### core/rqsb_defines.svh
`ifndef RQSB_DEFINES_SVH
`define RQSB_DEFINES_SVH

// Sideband field positions
`define RQSB_SB_W        60
`define RQSB_HEADBE_LO   0
`define RQSB_TAILBE_LO   4
`define RQSB_OFFS_LO     8
`define RQSB_ABORT_BIT   11
`define RQSB_HINT_BIT    12
`define RQSB_HTYPE_LO    13
`define RQSB_INDIR_BIT   15
`define RQSB_STEER_LO    16
`define RQSB_SEQ_LO      24
`define RQSB_PAR_LO      28
`define RQSB_PAR_W       32

// Default data width and steering table depth
`define RQSB_DATA_W      256
`define RQSB_STT_DEPTH   64

`endif

// ### core/rqsb_pkg.sv
package rqsb_pkg;

   // Fields captured from the first accepted beat of a request
   typedef struct packed {
      logic [3:0] headDwordByteEnables;
      logic [3:0] tailDwordByteEnables;
      logic [2:0] alignOffset;
      logic       hintPresent;
      logic [1:0] hintType;
      logic       hintIndirect;
      logic [7:0] hintSteeringValue;
      logic [3:0] progressNumber;
   } rqsb_hdr_t;

   // Per-packet result handed downstream on the final beat
   typedef struct packed {
      rqsb_hdr_t  hdr;
      logic [7:0] steeringTag;
      logic       nullify;
      logic       parityBad;
      logic       aborted;
   } rqsb_res_t;

endpackage

// ### core/rqsb_skid_buffer.sv
`timescale 1ns/1ns
// Two-entry buffer, registered data, full throughput without a comb path
// from the output ready back to the input ready.
module rqsb_skid_buffer #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);

   typedef struct packed {
      logic [WIDTH-1:0] mem0;
      logic [WIDTH-1:0] mem1;
      logic [1:0]       count;
   } rqsb_skid_st_t;

   rqsb_skid_st_t st_reg;
   rqsb_skid_st_t st_next;

   logic doPush;
   logic doPop;

   assign inReady  = (st_reg.count != 2'h2);
   assign outValid = (st_reg.count != 2'h0);
   assign outData  = st_reg.mem0;
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;

   // Entry 0 is always the head; entry 1 only holds the overflow word
   always_comb begin
      st_next = st_reg;
      if (doPop) begin
         st_next.mem0 = st_reg.mem1;
      end
      if (doPush) begin
         if (st_reg.count == 2'h0 || (st_reg.count == 2'h1 && doPop)) begin
            st_next.mem0 = inData;
         end else if (st_reg.count == 2'h2 && doPop) begin
            st_next.mem1 = inData;
         end else begin
            st_next.mem1 = inData;
         end
      end
      case ({doPush, doPop})
         2'b10:   st_next.count = st_reg.count + 2'h1;
         2'b01:   st_next.count = st_reg.count - 2'h1;
         default: st_next.count = st_reg.count;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

endmodule // rqsb_skid_buffer

// ### core/rqsb_requester_sideband.sv
// Function
// - Beat moves only when valid and ready; client holds beat while stalled.
// - Head Dword byte enables, bits 3:0, captured on first accepted beat.
// - Tail Dword byte enables, bits 7:4, captured on first accepted beat.
// - Bits 10:8 give start byte lane modulo 8 in address-aligned mode.
// - Abort flag bit 11 in any beat makes the device nullify the TLP.
// - Abort is sticky for the remaining beats of the packet.
// - As Endpoint, client abort is also reported through error reporting.
// - Bit 12 flags a hint, captured first beat; tied zero if unused.
// - Bits 14:13 hint type, captured first beat, ignored without hint.
// - Indirect bit 15 set: steering value indexes the steering tag table.
// - Indirect bit clear: steering value inserted directly as tag.
// - Bits 23:16 steering value, captured first beat, ignored without hint.
// - Echo 4-bit progress number from bits 27:24 once order is safe.
// - Only 16 parity bits at 128-bit width, 8 at 64-bit.
`timescale 1ns/1ns
`include "rqsb_defines.svh"
module rqsb_requester_sideband
   import rqsb_pkg::*;
#(
   parameter int DATA_W    = `RQSB_DATA_W,
   parameter int STT_DEPTH = `RQSB_STT_DEPTH
) (
   input  wire logic                    clk_sys,
   input  wire logic                    nrst,
   input  wire logic [DATA_W-1:0]       req_stream_payload,
   input  wire logic [`RQSB_SB_W-1:0]   req_sideband_bus,
   input  wire logic                    reqStreamLast,
   input  wire logic                    req_stream_valid,
   output logic                         req_stream_ready,
   input  wire logic                    addrAlignedMode,
   input  wire logic                    parityCheckEn,
   input  wire logic                    endpointMode,
   input  wire logic                    stTableWrEn,
   input  wire logic [$clog2(STT_DEPTH)-1:0] stTableWrIdx,
   input  wire logic [7:0]              stTableWrData,
   output logic [DATA_W-1:0]            txPayload,
   output logic                         txLast,
   output rqsb_res_t                    txResult,
   output logic                         txValid,
   input  wire logic                    txReady,
   output logic [3:0]                   progress_number_echo,
   output logic                         progressEchoValid,
   output logic                         abortAerReport,
   output logic                         internalErrReport
);

   // Lane count, table index width and buffer word layout
   localparam int NBYTES = DATA_W / 8;
   localparam int IDX_W  = $clog2(STT_DEPTH);
   localparam int BUF_W  = DATA_W + 1 + $bits(rqsb_res_t);

   // ****************************************************************
   // State
   // ****************************************************************
   // The steering table sits in the state word, so reset clears it too
   typedef struct packed {
      logic       inPacket;
      rqsb_hdr_t  hdr;
      logic       aborted;
      logic       parityBad;
      logic [3:0] echoNum;
      logic       echoValid;
      logic       aerPulse;
      logic       ierrPulse;
      logic [STT_DEPTH-1:0][7:0] stt;
   } rqsb_state_t;

   rqsb_state_t st_reg;
   rqsb_state_t st_next;

   // Per-beat decode, table index and buffer plumbing
   logic [IDX_W-1:0] tagIdx;
   logic       beatTaken;
   logic       bufInReady;
   logic       bufOutValid;
   logic       bufOutReady;
   logic [BUF_W-1:0] bufIn;
   logic [BUF_W-1:0] bufOut;
   rqsb_hdr_t  beatHdr;
   rqsb_hdr_t  curHdr;
   rqsb_res_t  res;
   logic       beatAbort;
   logic       beatParBad;
   logic [NBYTES-1:0] parMismatch;

   // Decode the header fields out of the sideband bus
   function automatic rqsb_hdr_t decode_hdr(input logic [`RQSB_SB_W-1:0] sb,
                                            input logic alignMode);
      rqsb_hdr_t h;
      h.headDwordByteEnables = sb[`RQSB_HEADBE_LO +: 4];
      h.tailDwordByteEnables = sb[`RQSB_TAILBE_LO +: 4];
      // Dword-aligned traffic has no lane offset, so it is forced to zero
      h.alignOffset  = alignMode ? sb[`RQSB_OFFS_LO +: 3] : 3'h0;
      h.hintPresent  = sb[`RQSB_HINT_BIT];
      // Hint fields are don't-care without a hint; clear them for clean tags
      h.hintType     = h.hintPresent ? sb[`RQSB_HTYPE_LO +: 2] : 2'h0;
      h.hintIndirect = h.hintPresent & sb[`RQSB_INDIR_BIT];
      h.hintSteeringValue = h.hintPresent ?
                            sb[`RQSB_STEER_LO +: 8] : 8'h00;
      h.progressNumber = sb[`RQSB_SEQ_LO +: 4];
      return h;
   endfunction

   // ****************************************************************
   // Beat acceptance and checks
   // ****************************************************************
   // Ready follows buffer room only, so a stall never drops a beat
   assign req_stream_ready = bufInReady;
   assign beatTaken = req_stream_valid && req_stream_ready;
   // Header fields count only on the first beat of a packet
   assign beatHdr   = decode_hdr(req_sideband_bus, addrAlignedMode);
   assign curHdr    = st_reg.inPacket ? st_reg.hdr : beatHdr;
   // Abort is only looked at on accepted beats
   assign beatAbort = beatTaken && req_sideband_bus[`RQSB_ABORT_BIT];

   // Per-byte odd parity; only lanes of the configured width exist
   genvar gi;
   generate
      for (gi = 0; gi < NBYTES; gi++) begin : g_par
         assign parMismatch[gi] =
            (^req_stream_payload[gi*8 +: 8]) ==
            req_sideband_bus[`RQSB_PAR_LO + gi];
      end
   endgenerate
   assign beatParBad = beatTaken && parityCheckEn && (|parMismatch);

   // Only the low value bits index the table; the rest are dropped
   assign tagIdx = curHdr.hintSteeringValue[IDX_W-1:0];

   // Steering tag: table lookup or direct value
   always_comb begin
      res.hdr = curHdr;
      if (curHdr.hintIndirect) begin
         res.steeringTag = st_reg.stt[tagIdx];
      end else begin
         res.steeringTag = curHdr.hintSteeringValue;
      end
      res.aborted     = st_reg.aborted || beatAbort;
      res.parityBad   = st_reg.parityBad || beatParBad;
      res.nullify     = res.aborted || res.parityBad;
   end

   // ****************************************************************
   // Packet tracking
   // ****************************************************************
   always_comb begin
      st_next = st_reg;
      st_next.echoValid = 1'b0;
      st_next.aerPulse  = 1'b0;
      st_next.ierrPulse = 1'b0;
      if (beatTaken) begin
         if (!st_reg.inPacket) begin
            st_next.hdr = beatHdr;
         end
         // Sticky until the end of packet, even if the flag drops
         st_next.aborted   = res.aborted;
         st_next.parityBad = res.parityBad;
         st_next.inPacket  = !reqStreamLast;
         // Error reports go out as the final beat is taken, not as it leaves
         if (reqStreamLast) begin
            st_next.aborted   = 1'b0;
            st_next.parityBad = 1'b0;
            st_next.aerPulse  = res.aborted && endpointMode;
            st_next.ierrPulse = res.parityBad;
         end
      end
      // Once the word leaves the buffer nothing from the client passes it;
      // a stalled receiver therefore also holds back the echo
      if (bufOutValid && bufOutReady && bufOut[BUF_W-1]) begin
         st_next.echoNum   = txResult.hdr.progressNumber;
         st_next.echoValid = 1'b1;
      end
      // Table writes may land in any cycle, inside a packet or not
      if (stTableWrEn) begin
         st_next.stt[stTableWrIdx] = stTableWrData;
      end
   end

   // Asynchronous clear of the whole state word, table included
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************************************
   // Output buffer
   // ****************************************************************
   // Last flag on top, result in the middle, payload at the bottom
   assign bufIn = {reqStreamLast, res, req_stream_payload};
   assign bufOutReady = txReady;

   rqsb_skid_buffer #(
      .WIDTH (BUF_W)
   ) u_buf (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .inData   (bufIn),
      .inValid  (req_stream_valid),
      .inReady  (bufInReady),
      .outData  (bufOut),
      .outValid (bufOutValid),
      .outReady (bufOutReady)
   );

   // Link side reads the buffer head; the report pulses are registered
   assign txPayload = bufOut[DATA_W-1:0];
   assign txResult  = bufOut[DATA_W +: $bits(rqsb_res_t)];
   assign txLast    = bufOut[BUF_W-1];
   assign txValid   = bufOutValid;
   assign progress_number_echo = st_reg.echoNum;
   assign progressEchoValid    = st_reg.echoValid;
   assign abortAerReport       = st_reg.aerPulse;
   assign internalErrReport    = st_reg.ierrPulse;

endmodule // rqsb_requester_sideband

// ### tb/rqsb_client_model.sv
`timescale 1ns/1ns
// ****
// Client model
// ****
module rqsb_client_model (
   input  wire logic        clk_sys,
   input  wire logic        req_stream_ready,
   output logic      [63:0] payload,
   output logic      [59:0] sideband,
   output logic             last,
   output logic             valid
);
   // Lines start idle so nothing is offered before reset ends
   initial begin
      valid = 1'h0;
      last = 1'h0;
      payload = '0;
      sideband = '0;
   end
   // Called just after an edge; holds the beat until the ready edge
   task send(input logic [63:0] d, input logic [59:0] s, input logic l);
      #1;
      payload = d;
      sideband = s;
      last = l;
      valid = 1'h1;
      do @(posedge clk_sys); while (req_stream_ready !== 1'h1);
   endtask
   // Released lines flip, so a stale beat can never pass as data
   task idle();
      #1;
      valid = 1'h0;
      payload = ~payload;
      sideband = ~sideband;
   endtask
endmodule // rqsb_client_model

// ### tb/rqsb_sideband_asserts.sv
`timescale 1ns/1ns
`include "rqsb_defines.svh"
// ****
// Checker
// ****
module rqsb_sideband_asserts
   import rqsb_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic       req_stream_valid,
   input wire logic       req_stream_ready,
   input wire logic [`RQSB_SB_W-1:0] req_sideband_bus,
   input wire logic       reqStreamLast,
   input wire logic       endpointMode,
   input wire logic       txValid,
   input wire logic       txReady,
   input wire logic       txLast,
   input wire rqsb_res_t  txResult,
   input wire logic [3:0] progress_number_echo,
   input wire logic       progressEchoValid,
   input wire logic       abortAerReport,
   input wire logic       internalErrReport
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Beat taken, final beat taken, final word leaving
   wire logic take = req_stream_valid && req_stream_ready;
   sequence s_endIn; take && reqStreamLast; endsequence
   sequence s_endOut; txValid && txReady && txLast; endsequence
   chk_take_forward: assert property (take |=> txValid)
      else $error("taken beat not forwarded");
   chk_head_hold: assert property (txValid && !txReady |=>
      txValid && $stable(txResult)) else $error("head changed in stall");
   chk_echo_value: assert property (s_endOut |=> progressEchoValid &&
      progress_number_echo == $past(txResult.hdr.progressNumber))
      else $error("echo wrong");
   chk_echo_cause: assert property (progressEchoValid |->
      $past(txValid && txReady && txLast)) else $error("stray echo");
   chk_err_cause: assert property (internalErrReport |->
      $past(take && reqStreamLast)) else $error("stray internal error");
   chk_aer_cause: assert property (abortAerReport |->
      $past(take && reqStreamLast && endpointMode)) else $error("stray aer");
   chk_aer_raise: assert property (s_endIn ##0
      (req_sideband_bus[`RQSB_ABORT_BIT] && endpointMode) |=> abortAerReport)
      else $error("abort not reported");
   chk_nullify_cause: assert property (txValid && txLast |->
      txResult.nullify == (txResult.aborted || txResult.parityBad))
      else $error("nullify wrong");
   chk_direct_tag: assert property (txValid && txLast &&
      txResult.hdr.hintPresent && !txResult.hdr.hintIndirect |->
      txResult.steeringTag == txResult.hdr.hintSteeringValue)
      else $error("direct tag wrong");
endmodule // rqsb_sideband_asserts

bind rqsb_requester_sideband rqsb_sideband_asserts chk_u (
   .clk_sys(clk_sys), .nrst(nrst), .req_stream_valid(req_stream_valid),
   .req_stream_ready(req_stream_ready), .reqStreamLast(reqStreamLast),
   .req_sideband_bus(req_sideband_bus),
   .endpointMode(endpointMode), .txValid(txValid), .txReady(txReady),
   .txLast(txLast), .txResult(txResult),
   .progress_number_echo(progress_number_echo),
   .progressEchoValid(progressEchoValid), .abortAerReport(abortAerReport),
   .internalErrReport(internalErrReport));

// ### tb/test_requester_request_sideband.sv
`timescale 1ns/1ns
module test_requester_request_sideband
   import rqsb_pkg::*;
;
   // ****
   // Bench
   // ****
   logic        clk_sys, nrst, alignMode, parEn, epMode, stWe, txReady;
   logic [5:0]  stIdx;
   logic [7:0]  stData;
   logic [63:0] pay, txPayload, d, paySeen;
   logic [59:0] sb;
   logic        last, valid, ready, txLast, txValid, echoV, aer, ierr;
   logic [3:0]  echo, echoSeen;
   rqsb_res_t   txResult, res;
   rqsb_hdr_t   h;
   int          n_mismatch, compares, nEcho, nAer, nErr;
   // Narrow bus so that the unused upper parity bits get exercised
   rqsb_requester_sideband #(.DATA_W(64), .STT_DEPTH(64)) dut_u (
      .clk_sys(clk_sys), .nrst(nrst), .req_stream_payload(pay),
      .req_sideband_bus(sb), .reqStreamLast(last), .req_stream_valid(valid),
      .req_stream_ready(ready), .addrAlignedMode(alignMode),
      .parityCheckEn(parEn), .endpointMode(epMode), .stTableWrEn(stWe),
      .stTableWrIdx(stIdx), .stTableWrData(stData), .txPayload(txPayload),
      .txLast(txLast), .txResult(txResult), .txValid(txValid),
      .txReady(txReady), .progress_number_echo(echo),
      .progressEchoValid(echoV), .abortAerReport(aer),
      .internalErrReport(ierr));
   rqsb_client_model cli_u (.clk_sys(clk_sys), .req_stream_ready(ready),
      .payload(pay), .sideband(sb), .last(last), .valid(valid));
   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Pulses are counted, so their timing is left to the checker
   always @(posedge clk_sys) begin
      if (txValid === 1'h1 && txReady === 1'h1 && txLast === 1'h1) begin
         res <= txResult;
         paySeen <= txPayload;
      end
      if (echoV === 1'h1) nEcho <= nEcho + 1;
      if (echoV === 1'h1) echoSeen <= echo;
      if (aer === 1'h1) nAer <= nAer + 1;
      if (ierr === 1'h1) nErr <= nErr + 1;
   end
   task check(input string what, input logic [63:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task end_of_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Sideband from header fields, abort flag and parity
   function logic [59:0] mk(rqsb_hdr_t x, logic ab, logic [31:0] p);
      return {p, x.progressNumber, x.hintSteeringValue, x.hintIndirect,
         x.hintType, x.hintPresent, ab, x.alignOffset,
         x.tailDwordByteEnables, x.headDwordByteEnables};
   endfunction
   function logic [31:0] par(logic [63:0] v);
      par = '0;
      for (int i = 0; i < 8; i++) par[i] = ~^v[8*i +: 8];
   endfunction
   // Config change plus a table write of entry 5, ends on an edge
   task cfg(input logic a, p, e, r);
      @(posedge clk_sys);
      #1;
      {alignMode, parEn, epMode, txReady, stWe} = {a, p, e, r, 1'h1};
      @(posedge clk_sys);
      #1;
      stWe = 1'h0;
      @(posedge clk_sys);
   endtask
   task wait_echo(input int n);
      for (int i = 0; i < 40 && nEcho < n; i++) @(posedge clk_sys);
      check("echo count", nEcho, n);
   endtask
   task t_capture();
      cfg(1'h1, 1'h1, 1'h0, 1'h1);
      h = {4'h3, 4'hc, 3'h2, 1'h1, 2'h2, 1'h0, 8'ha7, 4'h9};
      d = 64'h0123456789abcdef;
      cli_u.send(d, mk(h, 1'h0, par(d)), 1'h0);
      cli_u.send(~d, mk(~h, 1'h0, par(~d)), 1'h1);
      cli_u.idle();
      wait_echo(1);
      check("hdr", res.hdr, h);
      check("tag", res.steeringTag, 8'ha7);
      check("echo", echoSeen, 4'h9);
      check("nullify", res.nullify, 1'h0);
      check("payload", paySeen, ~d);
      $display("capture test done");
   endtask
   // Receiver stalls, the third beat is refused, abort drops early
   task t_abort();
      cfg(1'h0, 1'h0, 1'h1, 1'h0);
      h = {4'h1, 4'h2, 3'h0, 1'h1, 2'h1, 1'h1, 8'h45, 4'h0};
      cli_u.send(d, mk(h, 1'h0, '0), 1'h0);
      cli_u.send(d, mk(h, 1'h1, '0), 1'h0);
      fork
         cli_u.send(d, mk(h, 1'h0, '0), 1'h1);
         begin
            #2 check("ready full", ready, 1'h0);
            repeat (4) @(posedge clk_sys);
            #1 txReady = 1'h1;
         end
      join
      cli_u.idle();
      wait_echo(2);
      check("aborted", res.aborted, 1'h1);
      check("nullify", res.nullify, 1'h1);
      check("parity", res.parityBad, 1'h0);
      check("table tag", res.steeringTag, 8'h3c);
      check("aer", nAer, 1);
      $display("abort test done");
   endtask
   task t_parity();
      cfg(1'h1, 1'h1, 1'h0, 1'h1);
      h = {4'h1, 4'h0, 3'h1, 1'h0, 2'h3, 1'h1, 8'hff, 4'h5};
      cli_u.send(d, mk(h, 1'h0, par(d) | 32'hffffff00), 1'h1);
      cli_u.idle();
      wait_echo(3);
      check("upper ignored", res.parityBad, 1'h0);
      check("no hint type", res.hdr.hintType, 2'h0);
      check("no hint tag", res.hdr.hintSteeringValue, 8'h00);
      // Second packet only after the first is judged, so res is not overrun
      cli_u.send(d, mk(h, 1'h0, par(d) ^ 32'h1), 1'h1);
      cli_u.idle();
      wait_echo(4);
      check("bad parity", res.nullify & res.parityBad, 1'h1);
      check("internal err", nErr, 1);
      $display("parity test done");
   endtask
   initial begin
      {n_mismatch, compares, nEcho, nAer, nErr} = '0;
      {nrst, alignMode, parEn, epMode, stWe, txReady} = '0;
      stIdx = 6'h05;
      stData = 8'h3c;
      repeat (5) @(posedge clk_sys);
      #1 nrst = 1'h1;
      t_capture();
      t_abort();
      t_parity();
      end_of_test();
   end
   // About forty cycles are expected; five hundred means a hang
   initial begin
      #5000;
      n_mismatch++;
      end_of_test();
   end
endmodule // test_requester_request_sideband
